// file: logic/egr_rx_overhead_regs.sv
// Receive overhead field and error count register group for one E3 G.832 port.
// Assumes the framer gives same-clock pulses and a per-frame overhead strobe,
// and that the global port status enable comes from the global register block.
// Count registers show the last interval only; live counters are not visible.
// The port interrupt is a level and drops as soon as software clears the flags.
`timescale 1ns/1ps

module egr_rx_overhead_regs
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic        reg_cs,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	// Framer side
	input  wire logic        oh_valid,
	input  wire logic [7:0]  rx_ma_byte,
	input  wire logic [7:0]  rx_nr_byte,
	input  wire logic [7:0]  rx_gc_byte,
	input  wire logic        framing_err_evt,
	input  wire logic        parity_err_evt,
	input  wire logic        remote_err_evt,
	input  wire logic        perf_monitor_update,
	input  wire logic        timing_extract_en,
	input  wire logic        global_port_status_irq_en,
	output logic             port_irq
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [15:0]         irq_en;
		logic [15:0]         latched;
		logic [15:0]         fe_live;
		logic [15:0]         pe_live;
		logic [15:0]         re_live;
		logic [15:0]         framing_err_count;
		logic [15:0]         parity_err_count;
		logic [15:0]         remote_err_count;
		logic [2:0]          cnt_status;
		logic [3:0]          mf_bits;
		egr_pkg::egr_integ_s pt;
		egr_pkg::egr_integ_s ti_raw;
		egr_pkg::egr_integ_s ti_mf;
		egr_pkg::egr_integ_s nr;
		egr_pkg::egr_integ_s gc;
		logic [15:0]         rdata;
	} egr_state_s;

	egr_state_s st_q;
	egr_state_s st_d;

	// ==========================================================
	// Helpers
	// A field is accepted only after the same value repeats for INTEG_FRAMES
	function automatic egr_pkg::egr_integ_s integ_step(input egr_pkg::egr_integ_s s,
		input logic [7:0] v);
		egr_pkg::egr_integ_s r;
		r = s;
		if (v != s.cand)
		begin
			r.cand = v;
			r.cnt  = 4'h1;
		end
		else if (s.cnt < egr_pkg::INTEG_FRAMES)
		begin
			r.cnt = s.cnt + 4'h1;
		end
		if (r.cnt >= egr_pkg::INTEG_FRAMES)
		begin
			r.val = r.cand;
		end
		return r;
	endfunction : integ_step

	// Saturating so a long interval never wraps back to a small figure
	function automatic logic [15:0] count_step(input logic [15:0] c, input logic ev);
		logic [15:0] r;
		r = c;
		if (ev && (c != egr_pkg::COUNT_MAX))
		begin
			r = c + 16'h0001;
		end
		return r;
	endfunction : count_step

	function automatic logic is_nonzero(input logic [15:0] w);
		return (w != egr_pkg::RESET_WORD);
	endfunction : is_nonzero

	function automatic logic [15:0] live_restart(input logic ev);
		return {15'h0000, ev};
	endfunction : live_restart

	function automatic logic rose_edge(input logic now_v, input logic was_v);
		return now_v & ~was_v;
	endfunction : rose_edge

	// Clear before set, so an event in the clearing cycle is never lost
	function automatic logic [15:0] latch_update(input logic [15:0] cur, input logic [15:0] clr,
		input logic [15:0] set_v);
		logic [15:0] r;
		r = cur & ~clr;
		r = r | set_v;
		return r & egr_pkg::IMPL_MASK;
	endfunction : latch_update

	// Extraction only changes the low nibble; payload type reads the same either way
	function automatic logic [15:0] ma_field_word(input logic [2:0] pt, input logic [3:0] ti_mf,
		input logic [2:0] ti_raw, input logic ext);
		logic [15:0] w;
		w = egr_pkg::RESET_WORD;
		w[6:4] = pt;
		if (ext)
		begin
			w[3:0] = ti_mf;
		end
		else
		begin
			w[3:0] = {1'b0, ti_raw};
		end
		return w;
	endfunction : ma_field_word

	// One term per enable bit; the global enable gates the whole port
	function automatic logic port_request(input logic [15:0] lat, input logic [15:0] en,
		input logic gl);
		logic hit;
		hit = 1'b0;
		if (lat[egr_pkg::BIT_REMOTE_ERR] && en[egr_pkg::BIT_REMOTE_ERR])
		begin
			hit = 1'b1;
		end
		if (lat[egr_pkg::BIT_PARITY_ERR] && en[egr_pkg::BIT_PARITY_ERR])
		begin
			hit = 1'b1;
		end
		if (lat[egr_pkg::BIT_FRAMING_ERR] && en[egr_pkg::BIT_FRAMING_ERR])
		begin
			hit = 1'b1;
		end
		if (lat[egr_pkg::BIT_REMOTE_CNT] && en[egr_pkg::BIT_REMOTE_CNT])
		begin
			hit = 1'b1;
		end
		if (lat[egr_pkg::BIT_PARITY_CNT] && en[egr_pkg::BIT_PARITY_CNT])
		begin
			hit = 1'b1;
		end
		if (lat[egr_pkg::BIT_FRAMING_CNT] && en[egr_pkg::BIT_FRAMING_CNT])
		begin
			hit = 1'b1;
		end
		return hit && gl;
	endfunction : port_request

	// ==========================================================
	// Next state
	logic [3:0]  mf_next;
	logic [2:0]  cnt_status_new;
	logic [15:0] set_mask;
	logic [15:0] clr_mask;
	logic [15:0] ma_word;
	logic        wr_req;
	logic        rd_req;

	always_comb
	begin
		st_d           = st_q;
		mf_next        = st_q.mf_bits;
		cnt_status_new = st_q.cnt_status;
		set_mask       = egr_pkg::RESET_WORD;
		clr_mask       = egr_pkg::RESET_WORD;
		ma_word        = egr_pkg::RESET_WORD;
		wr_req         = reg_cs && reg_wr;
		rd_req         = reg_cs && reg_rd;

		// Overhead integration, one step per received frame
		if (oh_valid)
		begin
			st_d.pt     = integ_step(st_q.pt, {5'h00, rx_ma_byte[5:3]});
			st_d.ti_raw = integ_step(st_q.ti_raw, {5'h00, rx_ma_byte[2:0]});
			st_d.nr     = integ_step(st_q.nr, rx_nr_byte);
			st_d.gc     = integ_step(st_q.gc, rx_gc_byte);
			// Two MA bits index a four-frame multiframe, each frame carries one bit in MA bit 0
			mf_next[rx_ma_byte[2:1]] = rx_ma_byte[0];
			st_d.mf_bits = mf_next;
			if (rx_ma_byte[2:1] == egr_pkg::MF_LAST_INDEX)
			begin
				st_d.ti_mf = integ_step(st_q.ti_mf, {4'h0, mf_next});
			end
		end

		// Live counters run between update strobes
		st_d.fe_live = count_step(st_q.fe_live, framing_err_evt);
		st_d.pe_live = count_step(st_q.pe_live, parity_err_evt);
		st_d.re_live = count_step(st_q.re_live, remote_err_evt);
		if (perf_monitor_update)
		begin
			// An event in the strobe cycle goes into the next interval
			st_d.framing_err_count = st_q.fe_live;
			st_d.parity_err_count  = st_q.pe_live;
			st_d.remote_err_count  = st_q.re_live;
			st_d.fe_live = live_restart(framing_err_evt);
			st_d.pe_live = live_restart(parity_err_evt);
			st_d.re_live = live_restart(remote_err_evt);
			cnt_status_new[0] = is_nonzero(st_q.fe_live);
			cnt_status_new[1] = is_nonzero(st_q.pe_live);
			cnt_status_new[2] = is_nonzero(st_q.re_live);
		end
		st_d.cnt_status = cnt_status_new;

		set_mask[egr_pkg::BIT_FRAMING_ERR] = framing_err_evt;
		set_mask[egr_pkg::BIT_PARITY_ERR]  = parity_err_evt;
		set_mask[egr_pkg::BIT_REMOTE_ERR]  = remote_err_evt;
		set_mask[egr_pkg::BIT_FRAMING_CNT] = rose_edge(cnt_status_new[0], st_q.cnt_status[0]);
		set_mask[egr_pkg::BIT_PARITY_CNT]  = rose_edge(cnt_status_new[1], st_q.cnt_status[1]);
		set_mask[egr_pkg::BIT_REMOTE_CNT]  = rose_edge(cnt_status_new[2], st_q.cnt_status[2]);

		// Writes: latched bits clear on one, a same-cycle set still wins
		if (wr_req)
		begin
			unique case (reg_addr)
				egr_pkg::ADDR_LATCHED:
				begin
					clr_mask = reg_wdata;
				end
				egr_pkg::ADDR_IRQ_EN:
				begin
					st_d.irq_en = reg_wdata & egr_pkg::IMPL_MASK;
				end
				default:
				begin
				end
			endcase
		end
		st_d.latched = latch_update(st_q.latched, clr_mask, set_mask);

		ma_word = ma_field_word(st_q.pt.val[2:0], st_q.ti_mf.val[3:0], st_q.ti_raw.val[2:0],
			timing_extract_en);

		// Read data is registered; unmapped addresses read zero
		if (rd_req)
		begin
			unique case (reg_addr)
				egr_pkg::ADDR_LATCHED:
				begin
					st_d.rdata = st_q.latched;
				end
				egr_pkg::ADDR_IRQ_EN:
				begin
					st_d.rdata = st_q.irq_en;
				end
				egr_pkg::ADDR_MA_FIELDS:
				begin
					st_d.rdata = ma_word;
				end
				egr_pkg::ADDR_NR_GC:
				begin
					st_d.rdata = {st_q.gc.val, st_q.nr.val};
				end
				egr_pkg::ADDR_FE_COUNT:
				begin
					st_d.rdata = st_q.framing_err_count;
				end
				egr_pkg::ADDR_PE_COUNT:
				begin
					st_d.rdata = st_q.parity_err_count;
				end
				egr_pkg::ADDR_RE_COUNT:
				begin
					st_d.rdata = st_q.remote_err_count;
				end
				default:
				begin
					st_d.rdata = egr_pkg::RESET_WORD;
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			st_q.irq_en            <= egr_pkg::RESET_WORD;
			st_q.latched           <= egr_pkg::RESET_WORD;
			st_q.fe_live           <= egr_pkg::RESET_WORD;
			st_q.pe_live           <= egr_pkg::RESET_WORD;
			st_q.re_live           <= egr_pkg::RESET_WORD;
			st_q.framing_err_count <= egr_pkg::RESET_WORD;
			st_q.parity_err_count  <= egr_pkg::RESET_WORD;
			st_q.remote_err_count  <= egr_pkg::RESET_WORD;
			st_q.cnt_status        <= 3'h0;
			st_q.mf_bits           <= 4'h0;
			st_q.pt                <= egr_pkg::INTEG_RESET;
			st_q.ti_raw            <= egr_pkg::INTEG_RESET;
			st_q.ti_mf             <= egr_pkg::INTEG_RESET;
			st_q.nr                <= egr_pkg::INTEG_RESET;
			st_q.gc                <= egr_pkg::INTEG_RESET;
			st_q.rdata             <= egr_pkg::RESET_WORD;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs
	always_comb
	begin
		port_irq = port_request(st_q.latched, st_q.irq_en, global_port_status_irq_en);
	end

	assign reg_rdata = st_q.rdata;

endmodule : egr_rx_overhead_regs

// file: logic/egr_pkg.sv
// Package for the E3 G.832 receive overhead and error count register group.
// Assumes one register port per framer port, byte addressed, 16-bit words.
package egr_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_LATCHED   = 8'h2A;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h2E;
	localparam logic [7:0] ADDR_MA_FIELDS = 8'h30;
	localparam logic [7:0] ADDR_NR_GC     = 8'h32;
	localparam logic [7:0] ADDR_FE_COUNT  = 8'h34;
	localparam logic [7:0] ADDR_PE_COUNT  = 8'h36;
	localparam logic [7:0] ADDR_RE_COUNT  = 8'h38;

	// ==========================================================
	// Field positions, shared by the latched and enable registers
	localparam int BIT_REMOTE_ERR = 10;
	localparam int BIT_PARITY_ERR = 9;
	localparam int BIT_FRAMING_ERR = 8;
	localparam int BIT_REMOTE_CNT = 2;
	localparam int BIT_PARITY_CNT = 1;
	localparam int BIT_FRAMING_CNT = 0;
	localparam logic [15:0] IMPL_MASK = 16'h0707;

	// ==========================================================
	// Reset values and counts
	localparam logic [15:0] RESET_WORD    = 16'h0000;
	localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
	localparam logic [3:0]  INTEG_FRAMES  = 4'h3;
	localparam logic [1:0]  MF_LAST_INDEX = 2'h3;

	// ==========================================================
	// Integrator state for one overhead field
	typedef struct packed {
		logic [3:0] cnt;
		logic [7:0] cand;
		logic [7:0] val;
	} egr_integ_s;

	localparam egr_integ_s INTEG_RESET = '{cnt: 4'h0, cand: 8'h00, val: 8'h00};

endpackage : egr_pkg

// file: bench/egr_rx_overhead_regs_asserts.sv
// Checker for the receive overhead register group, bound to its ports.
// Assumes a synchronous reset and writes only through the register port.
`timescale 1ns/1ps
module egr_rx_overhead_regs_asserts
(
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic        reg_cs,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        framing_err_evt,
	input wire logic        parity_err_evt,
	input wire logic        remote_err_evt,
	input wire logic        perf_monitor_update,
	input wire logic        global_port_status_irq_en,
	input wire logic        port_irq
);
	// ====================
	// Shadow enable word and framing counter
	logic [15:0] en_q;
	logic [15:0] live_q;
	logic [15:0] snap_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			en_q   <= 16'h0000;
			live_q <= 16'h0000;
			snap_q <= 16'h0000;
		end
		else
		begin
			if (reg_cs && reg_wr && reg_addr == egr_pkg::ADDR_IRQ_EN)
				en_q <= reg_wdata & 16'h0707;
			if (perf_monitor_update)
			begin
				snap_q <= live_q;
				live_q <= {15'h0000, framing_err_evt};
			end
			else if (framing_err_evt && live_q != 16'hFFFF)
				live_q <= live_q + 16'h0001;
		end
	end
	// ====================
	// Properties
	sequence s_armed(e, b);
		e && en_q[b] && global_port_status_irq_en;
	endsequence
	sequence s_read(a);
		reg_cs && reg_rd && reg_addr == a;
	endsequence
	property p_evt_irq(e, b);
		s_armed(e, b) ##1 (en_q[b] && global_port_status_irq_en) |-> port_irq;
	endproperty
	chk_remote_irq: assert property (p_evt_irq(remote_err_evt, 10))
		else $error("remote error gave no interrupt");
	chk_parity_irq: assert property (p_evt_irq(parity_err_evt, 9))
		else $error("parity error gave no interrupt");
	chk_framing_irq: assert property (p_evt_irq(framing_err_evt, 8))
		else $error("framing error gave no interrupt");
	chk_count_irq: assert property (p_evt_irq(perf_monitor_update &&
		live_q != 16'h0000 && snap_q == 16'h0000, 0))
		else $error("count flag gave no interrupt");
	chk_irq_gated: assert property
		((!global_port_status_irq_en || en_q == 16'h0000) |-> !port_irq)
		else $error("interrupt while gated off");
	chk_fe_count: assert property
		(s_read(egr_pkg::ADDR_FE_COUNT) |=> reg_rdata == $past(snap_q))
		else $error("framing count read mismatch");
	chk_en_readback: assert property
		(s_read(egr_pkg::ADDR_IRQ_EN) |=> reg_rdata == $past(en_q))
		else $error("enable read mismatch");
	chk_reset_quiet: assert property
		($past(sys_rst) |-> reg_rdata == 16'h0000 && !port_irq)
		else $error("outputs not clear after reset");
endmodule : egr_rx_overhead_regs_asserts

bind egr_rx_overhead_regs egr_rx_overhead_regs_asserts u_chk (.mclk, .sys_rst, .reg_cs,
	.reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .framing_err_evt, .parity_err_evt,
	.remote_err_evt, .perf_monitor_update, .global_port_status_irq_en, .port_irq);

// file: bench/tb_top.sv
// Self-checking bench for the receive overhead register group.
// Assumes package, design and checker are compiled first.
`timescale 1ns/1ps
module tb_top;
	logic        mclk, sys_rst, reg_cs, reg_rd, reg_wr, oh_valid, gen, ext;
	logic [7:0]  reg_addr, ma, nr, gc;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [3:0]  evt;
	logic        port_irq;
	int          mismatches, cmp_count;
	egr_rx_overhead_regs dut (.mclk, .sys_rst, .reg_cs, .reg_rd, .reg_wr, .reg_addr,
		.reg_wdata, .reg_rdata, .oh_valid, .rx_ma_byte(ma), .rx_nr_byte(nr), .rx_gc_byte(gc),
		.framing_err_evt(evt[0]), .parity_err_evt(evt[1]), .remote_err_evt(evt[2]),
		.perf_monitor_update(evt[3]), .timing_extract_en(ext),
		.global_port_status_irq_en(gen), .port_irq);
	// ====================
	// Drivers
	task chk(input string n, input logic [15:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [15:0] v);
		@(negedge mclk);
		{reg_cs, reg_wr, reg_addr, reg_wdata} = {2'h3, a, v};
		@(negedge mclk);
		{reg_cs, reg_wr} = 2'h0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(negedge mclk);
		{reg_cs, reg_rd, reg_addr} = {2'h3, a};
		@(negedge mclk);
		{reg_cs, reg_rd} = 2'h0;
		d = reg_rdata;
	endtask : rd
	task pulse(input logic [3:0] e);
		@(negedge mclk);
		evt = e;
		@(negedge mclk);
		evt = 4'h0;
	endtask : pulse
	task frame(input logic [7:0] m, n, g);
		@(negedge mclk);
		{oh_valid, ma, nr, gc} = {1'h1, m, n, g};
		@(negedge mclk);
		oh_valid = 1'h0;
	endtask : frame
	// ====================
	// Scenarios
	task t_reset;
		wr(egr_pkg::ADDR_FE_COUNT, 16'hFFFF);
		wr(egr_pkg::ADDR_IRQ_EN, 16'hFFFF);
		rd(egr_pkg::ADDR_IRQ_EN);
		chk("enable mask", d, 16'h0707);
		wr(egr_pkg::ADDR_IRQ_EN, 16'h0000);
		for (int a = 16'h002A; a <= 16'h0038; a += 2)
		begin
			rd(a[7:0]);
			chk("reset word", d, 16'h0000);
		end
		$display("t_reset done");
	endtask : t_reset
	task t_counts;
		wr(egr_pkg::ADDR_IRQ_EN, 16'h0001);
		pulse(4'h7);
		pulse(4'h3);
		pulse(4'h1);
		rd(egr_pkg::ADDR_FE_COUNT);
		chk("count early", d, 16'h0000);
		pulse(4'h8);
		chk("count irq", {15'h0000, port_irq}, 16'h0001);
		rd(egr_pkg::ADDR_FE_COUNT);
		chk("fe count", d, 16'h0003);
		rd(egr_pkg::ADDR_PE_COUNT);
		chk("pe count", d, 16'h0002);
		rd(egr_pkg::ADDR_RE_COUNT);
		chk("re count", d, 16'h0001);
		rd(egr_pkg::ADDR_LATCHED);
		chk("latched", d, 16'h0707);
		wr(egr_pkg::ADDR_LATCHED, 16'hFFFF);
		chk("irq cleared", {15'h0000, port_irq}, 16'h0000);
		$display("t_counts done");
	endtask : t_counts
	task t_irq;
		for (int b = 0; b < 3; b++)
		begin
			wr(egr_pkg::ADDR_IRQ_EN, 16'h0700 ^ (16'h0100 << b));
			pulse(4'h1 << b);
			chk("masked irq", {15'h0000, port_irq}, 16'h0000);
			rd(egr_pkg::ADDR_LATCHED);
			chk("latched err", d, 16'h0100 << b);
			wr(egr_pkg::ADDR_IRQ_EN, 16'h0100 << b);
			chk("irq on", {15'h0000, port_irq}, 16'h0001);
			gen = 1'h0;
			@(posedge mclk);
			chk("global off", {15'h0000, port_irq}, 16'h0000);
			@(negedge mclk);
			gen = 1'h1;
			wr(egr_pkg::ADDR_LATCHED, 16'hFFFF);
			pulse(4'h1 << b);
			chk("irq direct", {15'h0000, port_irq}, 16'h0001);
			wr(egr_pkg::ADDR_LATCHED, 16'hFFFF);
		end
		$display("t_irq done");
	endtask : t_irq
	task t_oh;
		repeat (3) frame(8'hA5, 8'h3C, 8'hC3);
		rd(egr_pkg::ADDR_NR_GC);
		chk("nr gc", d, 16'hC33C);
		rd(egr_pkg::ADDR_MA_FIELDS);
		chk("ma fields", d, 16'h0045);
		repeat (2) frame(8'h5A, 8'h96, 8'h69);
		rd(egr_pkg::ADDR_NR_GC);
		chk("two frames", d, 16'hC33C);
		frame(8'h5A, 8'h96, 8'h69);
		rd(egr_pkg::ADDR_NR_GC);
		chk("nr gc new", d, 16'h6996);
		rd(egr_pkg::ADDR_MA_FIELDS);
		chk("ma new", d, 16'h0032);
		ext = 1'h1;
		repeat (3)
		begin
			frame(8'h01, 8'h96, 8'h69);
			frame(8'h02, 8'h96, 8'h69);
			frame(8'h05, 8'h96, 8'h69);
			frame(8'h07, 8'h96, 8'h69);
		end
		rd(egr_pkg::ADDR_MA_FIELDS);
		chk("ma extract", d, 16'h000D);
		ext = 1'h0;
		rd(egr_pkg::ADDR_MA_FIELDS);
		chk("ma raw", d, 16'h0002);
		$display("t_oh done");
	endtask : t_oh
	task t_cnt_irq;
		pulse(4'h8);
		pulse(4'h8);
		rd(egr_pkg::ADDR_PE_COUNT);
		chk("empty interval", d, 16'h0000);
		rd(egr_pkg::ADDR_LATCHED);
		chk("no count flag", d, 16'h0000);
		for (int b = 1; b < 3; b++)
		begin
			wr(egr_pkg::ADDR_IRQ_EN, 16'h0001 << b);
			pulse(4'h1 << b);
			pulse(4'h8);
			chk("count irq", {15'h0000, port_irq}, 16'h0001);
			rd(egr_pkg::ADDR_LATCHED);
			chk("count flag", d, 16'h0101 << b);
			wr(egr_pkg::ADDR_LATCHED, 16'hFFFF);
			chk("count irq clear", {15'h0000, port_irq}, 16'h0000);
		end
		$display("t_cnt_irq done");
	endtask : t_cnt_irq
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	initial
	begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end
	initial
	begin
		{sys_rst, reg_cs, reg_rd, reg_wr, oh_valid, gen, ext} = 7'h42;
		{reg_addr, reg_wdata, evt, ma, nr, gc} = '0;
		repeat (20) @(negedge mclk);
		sys_rst = 1'h0;
		t_reset;
		t_counts;
		t_irq;
		t_cnt_irq;
		t_oh;
		test_done;
	end
	initial
	begin
		repeat (2000) @(posedge mclk);
		mismatches++;
		test_done;
	end
endmodule : tb_top
